// >>> rtl/stm_pkg.sv
// Package for the sweep trigger mode controller: modes, sizes, timing counts.
// Assumes one 200 MHz clock and a sampled, signed trigger amplitude stream.
package stm_pkg;
   localparam int unsigned SAMPLE_W = 12;
   localparam int unsigned LEVEL_W = 8;
   localparam int unsigned CLK_MHZ = 200;
   // Free-run repetition limits as printed, in hertz
   localparam int unsigned PP_AUTO_MIN_HZ = 200;
   localparam int unsigned AUTO_MIN_HZ = 30;
   localparam int unsigned PP_AUTO_TIMEOUT = (CLK_MHZ * 1000000) / PP_AUTO_MIN_HZ;
   localparam int unsigned AUTO_TIMEOUT = (CLK_MHZ * 1000000) / AUTO_MIN_HZ;
   localparam int unsigned TIMEOUT_W = 32;
   // Level span in percent of peak-to-peak for peak tracking mode
   localparam int unsigned PP_LO_PCT = 10;
   localparam int unsigned PP_HI_PCT = 90;
   // Vertical divisions reached by the absolute level range
   localparam int unsigned LEVEL_DIVS = 8;
   localparam int unsigned COUNTS_PER_DIV = 16'h00c8;
   localparam int unsigned HOLDOFF_CYCLES = 16;

   typedef enum logic [1:0] {
      STM_PP_AUTO,
      STM_AUTO,
      STM_LEVEL_GATED,
      STM_ONE_SHOT
   } stm_mode_t;

   typedef struct packed {
      logic pp_auto;
      logic auto_free;
      logic level_gated_mode;
      logic one_shot_sweep_mode;
   } stm_mode_lamps_t;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] sample;
      logic valid;
   } stm_trig_t;
endpackage

// >>> rtl/stm_peak_track.sv
// Peak tracker: follows the trigger signal's max and min with slow decay.
// Assumes samples arrive with a valid qualifier on the module clock.
`timescale 1ns/1ps
module stm_peak_track #(
   parameter int unsigned W = stm_pkg::SAMPLE_W,
   parameter int unsigned DECAY_SHIFT = 10
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire stm_pkg::stm_trig_t trig_i,
   output logic signed [W-1:0] max_o,
   output logic signed [W-1:0] min_o
);
   logic [DECAY_SHIFT-1:0] decay_q;
   logic signed [W-1:0] s;

   assign s = trig_i.sample;

   // Decay lets the peaks follow a shrinking amplitude
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         decay_q <= '0;
      end else if (trig_i.valid) begin
         decay_q <= decay_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         max_o <= '0;
         min_o <= '0;
      end else if (trig_i.valid) begin
         if (s > max_o) begin
            max_o <= s;
         end else if (decay_q == '0 && max_o > min_o) begin
            max_o <= max_o - 1'b1;
         end
         if (s < min_o) begin
            min_o <= s;
         end else if (decay_q == '0 && min_o < max_o) begin
            min_o <= min_o + 1'b1;
         end
      end
   end
endmodule

// >>> rtl/stm_ctrl.sv
// Trigger mode controller: picks the sweep start source and drives lamps.
// Assumes a conditioned trigger sample stream and one-cycle button pulses.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps

// Overview of operation
// - Exactly one mode active, one lamp lit
// - Peak-tracking mode self-starts below 200 Hz
// - Level maps to 10..90 percent of peak
// - Threshold rescales with amplitude automatically
// - Fixed-level mode self-starts below 30 Hz
// - Fixed-level free-runs when level outside signal
// - Adequate trigger returns triggered sweep starts
// - Absolute level spans plus/minus eight divisions
// - Level-gated mode: no trigger, no sweep
// - Triggered lamp lit only while triggered
// - One arm press permits one sweep
// - Arm lamp lit from press until trigger
// - One-shot disarmed means no sweep
module stm_ctrl #(
   parameter int unsigned PP_TIMEOUT = stm_pkg::PP_AUTO_TIMEOUT,
   parameter int unsigned AUTO_TIMEOUT = stm_pkg::AUTO_TIMEOUT,
   parameter int unsigned HOLDOFF = stm_pkg::HOLDOFF_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire stm_pkg::stm_trig_t trig_i,
   input wire logic [stm_pkg::LEVEL_W-1:0] level_i,
   input wire logic slope_neg_i,
   input wire logic sel_pp_auto_i,
   input wire logic sel_auto_i,
   input wire logic sel_level_gated_i,
   input wire logic sel_one_shot_i,
   input wire logic arm_press_i,
   input wire logic sweep_busy_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic sweep_start_o,
   output logic triggered_lamp_o,
   output logic arm_lamp_o,
   output stm_pkg::stm_mode_lamps_t mode_lamps_o,
   output logic irq_o
);
   localparam int unsigned SW = stm_pkg::SAMPLE_W;
   localparam int unsigned LW = stm_pkg::LEVEL_W;
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_MASK = 4'h4;
   localparam logic [3:0] ADDR_TIMEOUT = 4'h8;
   localparam logic [3:0] ADDR_MODE = 4'hc;
   localparam int unsigned NEV = 3;

   stm_pkg::stm_mode_t mode_q;
   logic signed [SW-1:0] pk_max, pk_min;
   logic signed [SW-1:0] thresh_d, thresh_q;
   logic signed [SW-1:0] prev_q;
   logic prev_vld_q;
   logic edge_hit;
   logic [stm_pkg::TIMEOUT_W-1:0] idle_q, timeout_q;
   logic adequate;
   logic in_range;
   logic armed_q;
   logic [15:0] holdoff_q;
   logic free_start;
   logic trig_start;
   logic [NEV-1:0] status_q, mask_q, event_set;
   logic [31:0] rd_d;

   stm_peak_track #(
      .W(SW),
      .DECAY_SHIFT(10)
   ) u_peak (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .trig_i(trig_i),
      .max_o(pk_max),
      .min_o(pk_min)
   );

   // Mode select: later buttons do not stack, one mode at a time
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_q <= stm_pkg::STM_PP_AUTO;
      end else if (sel_pp_auto_i) begin
         mode_q <= stm_pkg::STM_PP_AUTO;
      end else if (sel_auto_i) begin
         mode_q <= stm_pkg::STM_AUTO;
      end else if (sel_level_gated_i) begin
         mode_q <= stm_pkg::STM_LEVEL_GATED;
      end else if (sel_one_shot_i) begin
         mode_q <= stm_pkg::STM_ONE_SHOT;
      end else if (reg_wr_i && reg_addr_i == ADDR_MODE) begin
         mode_q <= stm_pkg::stm_mode_t'(reg_wdata_i[1:0]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_lamps_o <= '0;
      end else begin
         mode_lamps_o.pp_auto <= (mode_q == stm_pkg::STM_PP_AUTO);
         mode_lamps_o.auto_free <= (mode_q == stm_pkg::STM_AUTO);
         mode_lamps_o.level_gated_mode <= (mode_q == stm_pkg::STM_LEVEL_GATED);
         mode_lamps_o.one_shot_sweep_mode <= (mode_q == stm_pkg::STM_ONE_SHOT);
      end
   end

   // Threshold: fraction of tracked peaks, or an absolute division span
   always_comb begin
      logic signed [SW+LW+1:0] span;
      logic signed [SW+LW+1:0] frac;
      logic signed [SW+LW+1:0] absl;
      span = '0;
      frac = '0;
      absl = '0;
      thresh_d = '0;
      if (mode_q == stm_pkg::STM_PP_AUTO) begin
         // Level 0..max spans 10..90 percent, rescaled each sample
         span = (SW+LW+2)'(pk_max) - (SW+LW+2)'(pk_min);
         frac = (SW+LW+2)'(stm_pkg::PP_LO_PCT * 255 + int'(level_i)
                * (stm_pkg::PP_HI_PCT - stm_pkg::PP_LO_PCT));
         thresh_d = SW'((SW+LW+2)'(pk_min) + (span * frac) / (100 * 255));
      end else begin
         // Level 0..255 maps to -8..+8 divisions
         // Signed math so settings below centre give negative levels
         absl = (SW+LW+2)'((int'(level_i) - 128)
                * int'(2 * stm_pkg::LEVEL_DIVS * stm_pkg::COUNTS_PER_DIV) / 256);
         thresh_d = SW'(absl);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         thresh_q <= '0;
      end else begin
         thresh_q <= thresh_d;
      end
   end

   // Edge detect on chosen slope; either slope works in every mode
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         prev_q <= '0;
         prev_vld_q <= 1'b0;
      end else if (trig_i.valid) begin
         prev_q <= trig_i.sample;
         prev_vld_q <= 1'b1;
      end
   end

   assign edge_hit = trig_i.valid && prev_vld_q &&
      (slope_neg_i ? (prev_q >= thresh_q && trig_i.sample < thresh_q)
                   : (prev_q < thresh_q && trig_i.sample >= thresh_q));
   assign in_range = (thresh_q <= pk_max) && (thresh_q >= pk_min);

   // Time since last valid edge against a programmable limit
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         idle_q <= '1;
      end else if (edge_hit) begin
         idle_q <= '0;
      end else if (idle_q != '1) begin
         idle_q <= idle_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         timeout_q <= stm_pkg::TIMEOUT_W'(PP_TIMEOUT);
      end else if (reg_wr_i && reg_addr_i == ADDR_TIMEOUT) begin
         timeout_q <= reg_wdata_i;
      end else if (sel_pp_auto_i) begin
         timeout_q <= stm_pkg::TIMEOUT_W'(PP_TIMEOUT);
      end else if (sel_auto_i || sel_level_gated_i || sel_one_shot_i) begin
         timeout_q <= stm_pkg::TIMEOUT_W'(AUTO_TIMEOUT);
      end
   end

   assign adequate = (idle_q < timeout_q);

   // One-shot arming
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         armed_q <= 1'b0;
      end else if (mode_q != stm_pkg::STM_ONE_SHOT) begin
         armed_q <= 1'b0;
      end else if (arm_press_i) begin
         armed_q <= 1'b1;
      end else if (trig_start) begin
         armed_q <= 1'b0;
      end
   end

   // Start decisions; holdoff spaces all starts, triggered and free-run, sweep_busy_i waits out a sweep
   always_comb begin
      trig_start = 1'b0;
      free_start = 1'b0;
      if (!sweep_busy_i && holdoff_q == '0) begin
         unique case (mode_q)
            stm_pkg::STM_PP_AUTO: begin
               trig_start = edge_hit;
               free_start = !adequate && !edge_hit;
            end
            stm_pkg::STM_AUTO: begin
               trig_start = edge_hit && in_range;
               free_start = !edge_hit && (!adequate || !in_range);
            end
            stm_pkg::STM_LEVEL_GATED: begin
               trig_start = edge_hit && in_range && adequate;
            end
            stm_pkg::STM_ONE_SHOT: begin
               trig_start = edge_hit && armed_q;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         holdoff_q <= '0;
      end else if (trig_start || free_start) begin
         holdoff_q <= 16'(HOLDOFF);
      end else if (holdoff_q != '0) begin
         holdoff_q <= holdoff_q - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sweep_start_o <= 1'b0;
         triggered_lamp_o <= 1'b0;
         arm_lamp_o <= 1'b0;
      end else begin
         sweep_start_o <= trig_start || free_start;
         if (trig_start) begin
            triggered_lamp_o <= 1'b1;
         end else if (free_start || !adequate) begin
            triggered_lamp_o <= 1'b0;
         end
         arm_lamp_o <= (mode_q == stm_pkg::STM_ONE_SHOT) &&
                       ((armed_q && !trig_start) || arm_press_i);
      end
   end

   // Events: triggered start, free-run start, one-shot done
   assign event_set = {trig_start && mode_q == stm_pkg::STM_ONE_SHOT, free_start, trig_start};

   // Set beats a same-cycle write-one clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         status_q <= '0;
      end else if (reg_wr_i && reg_addr_i == ADDR_STATUS) begin
         status_q <= (status_q & ~reg_wdata_i[NEV-1:0]) | event_set;
      end else begin
         status_q <= status_q | event_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mask_q <= '0;
      end else if (reg_wr_i && reg_addr_i == ADDR_MASK) begin
         mask_q <= reg_wdata_i[NEV-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_q & mask_q);
      end
   end

   always_comb begin
      rd_d = '0;
      unique case (reg_addr_i)
         ADDR_STATUS: rd_d = {29'h0, status_q};
         ADDR_MASK: rd_d = {29'h0, mask_q};
         ADDR_TIMEOUT: rd_d = timeout_q;
         ADDR_MODE: rd_d = {28'h0, triggered_lamp_o, armed_q, mode_q};
         default: rd_d = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rd_d;
      end else begin
         reg_rdata_o <= '0;
      end
   end
endmodule

// >>> bench/stm_ctrl_sva.sv
// Port checker for the trigger mode controller.
// Assumes the bench holds the ramp busy for a while after each start.
`timescale 1ns/1ps
module stm_ctrl_sva #(
   parameter int unsigned PP_TIMEOUT = stm_pkg::PP_AUTO_TIMEOUT,
   parameter int unsigned HOLDOFF = stm_pkg::HOLDOFF_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic arm_press_i,
   input wire logic sweep_busy_i,
   input wire logic sweep_start_o,
   input wire logic triggered_lamp_o,
   input wire logic arm_lamp_o,
   input wire stm_pkg::stm_mode_lamps_t mode_lamps_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic [31:0] idle_q;
   // Idle ramp time in peak mode; refused crossings may add one holdoff
   always_ff @(posedge clk_i) begin
      if (reset_i || sweep_start_o || sweep_busy_i || !mode_lamps_o.pp_auto) begin
         idle_q <= '0;
      end else begin
         idle_q <= idle_q + 32'h1;
      end
   end
   property p_one_mode;
      !$past(reset_i) |-> $onehot(mode_lamps_o);
   endproperty
   a_one_mode: assert property (p_one_mode) else $error("mode lamps not one-hot");
   property p_free_bound;
      idle_q <= PP_TIMEOUT + HOLDOFF + 8;
   endproperty
   a_free_bound: assert property (p_free_bound) else $error("no free-run start");
   property p_arm_set;
      mode_lamps_o.one_shot_sweep_mode && arm_press_i |=> arm_lamp_o;
   endproperty
   a_arm_set: assert property (p_arm_set) else $error("arm lamp not lit");
   property p_arm_clear;
      mode_lamps_o.one_shot_sweep_mode && sweep_start_o |-> !arm_lamp_o;
   endproperty
   a_arm_clear: assert property (p_arm_clear) else $error("arm lamp lit at start");
   property p_arm_hold;
      $fell(arm_lamp_o) && mode_lamps_o.one_shot_sweep_mode |-> sweep_start_o;
   endproperty
   a_arm_hold: assert property (p_arm_hold) else $error("arm dropped without sweep");
   property p_no_disarmed;
      mode_lamps_o.one_shot_sweep_mode && !arm_lamp_o |=> !sweep_start_o;
   endproperty
   a_no_disarmed: assert property (p_no_disarmed) else $error("sweep while disarmed");
   property p_trig_rise;
      $rose(triggered_lamp_o) |-> sweep_start_o;
   endproperty
   a_trig_rise: assert property (p_trig_rise) else $error("lamp lit without start");
   property p_gated;
      mode_lamps_o.level_gated_mode && sweep_start_o |-> triggered_lamp_o;
   endproperty
   a_gated: assert property (p_gated) else $error("untriggered gated sweep");
   c_trig: cover property (sweep_start_o && triggered_lamp_o);
   c_free: cover property (sweep_start_o && !triggered_lamp_o);
   c_shot: cover property (arm_lamp_o ##1 !arm_lamp_o);
endmodule

bind stm_ctrl stm_ctrl_sva #(.PP_TIMEOUT(PP_TIMEOUT), .HOLDOFF(HOLDOFF)) i_sva (
   .clk_i(clk_i),
   .reset_i(reset_i),
   .arm_press_i(arm_press_i),
   .sweep_busy_i(sweep_busy_i),
   .sweep_start_o(sweep_start_o),
   .triggered_lamp_o(triggered_lamp_o),
   .arm_lamp_o(arm_lamp_o),
   .mode_lamps_o(mode_lamps_o)
);

// >>> bench/stm_trig_src.sv
// Conditioned trigger source model: square wave of set period and size.
// Assumes the bench changes its settings only between runs.
`timescale 1ns/1ps
module stm_trig_src (
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic [15:0] period_i,
   input wire logic signed [stm_pkg::SAMPLE_W-1:0] amp_i,
   output stm_pkg::stm_trig_t trig_o
);
   logic [15:0] ph_q = 16'h0000;
   initial trig_o = '0;
   always @(posedge clk_i) begin
      ph_q <= (ph_q + 16'h1 >= period_i) ? 16'h0000 : ph_q + 16'h1;
      if (en_i) begin
         trig_o.valid <= 1'b1;
         trig_o.sample <= (ph_q < period_i / 2) ? amp_i : -amp_i;
      end else begin
         // Stale sample churns so no one may lean on it
         trig_o.valid <= 1'b0;
         trig_o.sample <= ~trig_o.sample;
      end
   end
endmodule

// >>> bench/tb_stm_ctrl.sv
// Self-checking bench for the trigger mode controller.
// Assumes short free-run timeouts set by parameter and a 30 cycle ramp.
`timescale 1ns/1ps
module tb_stm_ctrl;
   logic clk_i = 1'b0, reset_i = 1'b1, slope = 1'b0, arm = 1'b0, wr = 1'b0, rd = 1'b0;
   logic start, tl, al, irq, en = 1'b0, busy;
   logic [7:0] level = 8'h80, bcnt = 8'h00;
   logic [3:0] sel = 4'h0, addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [15:0] per = 16'd120;
   logic signed [11:0] amp = 12'sd400;
   stm_pkg::stm_trig_t trig;
   stm_pkg::stm_mode_lamps_t lamps;
   int mismatches = 0, num_checks = 0, ns, nt;
   initial forever #2.5 clk_i = ~clk_i;
   // Ramp stays busy after each start
   always @(posedge clk_i) bcnt <= start ? 8'd30 : bcnt - {7'h0, bcnt != 8'h00};
   assign busy = bcnt != 8'h00;
   stm_trig_src i_src (.clk_i(clk_i), .en_i(en), .period_i(per), .amp_i(amp), .trig_o(trig));
   stm_ctrl #(.PP_TIMEOUT(50), .AUTO_TIMEOUT(200)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
      .trig_i(trig), .level_i(level), .slope_neg_i(slope), .sel_pp_auto_i(sel[0]),
      .sel_auto_i(sel[1]), .sel_level_gated_i(sel[2]), .sel_one_shot_i(sel[3]),
      .arm_press_i(arm), .sweep_busy_i(busy), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sweep_start_o(start),
      .triggered_lamp_o(tl), .arm_lamp_o(al), .mode_lamps_o(lamps), .irq_o(irq));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         mismatches++;
      end
   endtask
   task automatic press(input int i);
      @(posedge clk_i) sel[i] <= 1'b1;
      @(posedge clk_i) sel <= 4'h0;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_i) begin wr <= 1'b1; addr <= a; wdata <= v; end
      @(posedge clk_i) wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_i) begin rd <= 1'b1; addr <= a; end
      @(posedge clk_i) rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic src(input logic [15:0] p, input int a, input logic [7:0] l, input logic s);
      @(posedge clk_i) begin en <= 1'b1; per <= p; amp <= 12'(a); level <= l; slope <= s; end
   endtask
   // Counts starts, and those with the lamp lit just after
   task automatic watch(input int n);
      ns = 0;
      nt = 0;
      repeat (n) begin
         @(posedge clk_i) #1;
         if (start === 1'b1) begin
            ns++;
            @(posedge clk_i) #1;
            nt += int'(tl === 1'b1);
         end
      end
   endtask
   task automatic t_modes;
      repeat (2) @(posedge clk_i);
      #1 chk("lamps", 32'h8, {28'h0, lamps});
      for (int i = 0; i < 4; i++) begin
         press(i);
         // Lamps follow the mode one edge later
         @(posedge clk_i) #1 chk("lamps", 32'h8 >> i, {28'h0, lamps});
      end
      $display("t_modes done");
   endtask
   task automatic t_rate;
      src(16'd120, 400, 8'h80, 1'b0);
      press(0);
      watch(600);
      watch(1000);
      chk("pp free", 32'h1, {31'h0, ns > nt});
      press(1);
      watch(600);
      watch(1000);
      chk("auto trig", 32'h1, {31'h0, ns > 0 && nt == ns});
      $display("t_rate done");
   endtask
   task automatic t_level;
      src(16'd120, 400, 8'hc0, 1'b0);
      watch(600);
      watch(800);
      chk("out of range", 32'h1, {31'h0, ns > 0 && nt == 0});
      press(2);
      watch(200);
      watch(800);
      chk("gated none", 32'h0, ns);
      src(16'd120, 400, 8'h80, 1'b1);
      watch(200);
      watch(800);
      chk("gated trig", 32'h1, {31'h0, ns > 0 && nt == ns});
      $display("t_level done");
   endtask
   task automatic t_pp;
      // Growing amplitudes: tracked peaks shrink only slowly
      for (int a = 400; a < 2000; a += 1100) begin
         src(16'd40, a, 8'h40, 1'b0);
         press(0);
         watch(600);
         watch(400);
         chk("pp trig", 32'h1, {31'h0, ns > 0 && nt == ns});
      end
      $display("t_pp done");
   endtask
   task automatic t_shot;
      int k;
      src(16'd120, 400, 8'h80, 1'b0);
      press(3);
      wreg(4'h0, 32'h7);
      watch(400);
      chk("disarmed", 32'h0, ns);
      @(posedge clk_i) arm <= 1'b1;
      @(posedge clk_i) arm <= 1'b0;
      #1 chk("armed", 32'h1, {31'h0, al});
      for (k = 0; k < 1000 && start !== 1'b1; k++) @(posedge clk_i) #1;
      if (k == 1000) begin
         mismatches++;
         finish_test();
      end
      chk("arm at start", 32'h0, {31'h0, al});
      watch(600);
      chk("one shot", 32'h0, ns);
      rreg(4'h0, d);
      chk("status", 32'h5, d);
      wreg(4'h4, 32'h4);
      @(posedge clk_i) #1 chk("irq on", 32'h1, {31'h0, irq});
      wreg(4'h4, 32'h0);
      @(posedge clk_i) #1 chk("irq masked", 32'h0, {31'h0, irq});
      wreg(4'h0, 32'h5);
      rreg(4'h0, d);
      chk("cleared", 32'h0, d);
      wreg(4'h8, 32'h64);
      rreg(4'h8, d);
      chk("timeout", 32'h64, d);
      rreg(4'h1, d);
      chk("unmapped", 32'h0, d);
      wreg(4'hc, 32'h2);
      rreg(4'hc, d);
      chk("mode reg", 32'h2, d & 32'h7);
      chk("lamps", 32'h2, {28'h0, lamps});
      $display("t_shot done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      t_modes();
      t_rate();
      t_level();
      t_pp();
      t_shot();
      finish_test();
   end
endmodule
